// >>> pkg/sbl_defines.svh
// offsets, fields, reset values and timing counts of the boot loader
`ifndef SBL_DEFINES_SVH
`define SBL_DEFINES_SVH

// register offsets (byte addresses)
`define SBL_OFF_PROT 8'h00
`define SBL_OFF_STAT 8'h04
`define SBL_OFF_CTRL 8'h08
`define SBL_OFF_CRC 8'h0c

// protection word fields
`define SBL_B_JTAG_OFF 0
`define SBL_B_LINK_OFF 1
`define SBL_B_OTP_BOOT 5
`define SBL_B_REDUND 7
`define SBL_B_LOCK0 8
`define SBL_B_MASTER 12
`define SBL_B_JTAG_OTP 13
`define SBL_B_DBG_OFF 14

// image and crc constants
`define SBL_SKIP_WORD 32'h0d15ab1e
`define SBL_CRC_POLY 32'hedb88320
`define SBL_CRC_INIT 32'hffffffff
`define SBL_RAM_BASE 16'h0000
`define SBL_OTP_BOOT_ROW 11'h000
`define SBL_OTP_SEC_ROW 11'h7ff

// otp programming port resource ids
`define SBL_RID_ADDR 24'h100200
`define SBL_RID_DATA 24'h200100
`define SBL_RID_CTRL 24'h100300

// internal reset delay, 15 us least at 100 ns clock
`define SBL_CLK_NS 100
`define SBL_BOOT_DLY_NS 15000
`define SBL_BOOT_DLY_CYC ((`SBL_BOOT_DLY_NS + `SBL_CLK_NS - 1) / `SBL_CLK_NS)

`endif

// >>> pkg/sbl_pkg.sv
// types of the boot loader
package sbl_pkg;

    typedef enum logic [3:0]
    {
        SBL_WAIT = 4'h0,
        SBL_SEC_REQ = 4'h1,
        SBL_SEC_GET = 4'h3,
        SBL_LEN = 4'h2,
        SBL_PROG = 4'h6,
        SBL_CHK = 4'h7,
        SBL_VERIFY = 4'h5,
        SBL_RUN = 4'h4,
        SBL_FAIL = 4'hc
    } sbl_state_e;

endpackage : sbl_pkg

// >>> verilog/sbl_loader.sv
// boot image loader and protection word enforcement for one tile
`include "sbl_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module sbl_loader
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic flash_rd_en,
    input wire logic flash_valid,
    input wire logic [7:0] flash_byte,
    output logic otp_rd_en,
    output logic [10:0] otp_rd_addr,
    input wire logic [31:0] otp_rd_data,
    output logic otp_redund_en,
    input wire logic [23:0] port_res_id,
    input wire logic [31:0] port_wdata,
    input wire logic port_wr,
    input wire logic port_from_jtag,
    output logic otp_wr_en,
    output logic otp_wr_sec,
    output logic [10:0] otp_wr_addr,
    output logic [31:0] otp_wr_data,
    output logic prog_refused,
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [31:0] ram_wdata,
    output logic cpu_run,
    output logic [15:0] cpu_start_addr,
    output logic boot_fail,
    output logic gpio_pd_en,
    output logic jtag_deny,
    output logic jtag_otp_deny,
    output logic link_deny,
    input wire logic debug_n_i,
    output logic debug_n_o,
    output logic debug_n_oe,
    output logic debug_enter,
    output logic [9:0] user_code_ext
);

    localparam int DLY_M1 = `SBL_BOOT_DLY_CYC - 1;

    typedef struct packed
    {
        sbl_pkg::sbl_state_e st;
        logic [7:0] dly;
        logic pd;
        logic [31:0] sec;
        logic sec_ok;
        logic src_otp;
        logic [31:0] shift;
        logic [1:0] bcnt;
        logic [31:0] len;
        logic [31:0] wcnt;
        logic [31:0] crc;
        logic [31:0] otp_buf;
        logic [2:0] otp_cnt;
        logic otp_pend;
        logic [10:0] otp_addr;
        logic ram_we;
        logic [15:0] ram_addr;
        logic [31:0] ram_wdata;
        logic run;
        logic fail;
        logic [31:0] rdata;
        logic brk;
        logic dbg_s1;
        logic dbg_s2;
        logic dbg_enter;
        logic [15:0] p_addr;
        logic [31:0] p_data;
        logic wr_en;
        logic wr_sec;
        logic [10:0] wr_addr;
        logic [31:0] wr_data;
        logic refused;
    } sbl_state_s;

    sbl_state_s s_reg;
    sbl_state_s s_next;

    // one byte into a reflected crc
    function automatic logic [31:0] sbl_crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] x;
        x = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++)
        begin
            x = x[0] ? ((x >> 1) ^ `SBL_CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction : sbl_crc_byte

    logic consuming;
    logic byte_ok;
    logic take;
    logic [7:0] in_byte;
    logic [31:0] word_in;
    logic otp_fetch;
    logic go;
    logic [1:0] sector;
    logic blocked;

    // ---------------------------------------------------------------
    // byte source
    // ---------------------------------------------------------------
    assign consuming = (s_reg.st == sbl_pkg::SBL_LEN) || (s_reg.st == sbl_pkg::SBL_PROG)
        || (s_reg.st == sbl_pkg::SBL_CHK);
    assign byte_ok = s_reg.src_otp ? (s_reg.otp_cnt != 3'h0) : flash_valid;
    assign take = consuming && byte_ok;
    assign in_byte = s_reg.src_otp ? s_reg.otp_buf[7:0] : flash_byte;
    assign word_in = {in_byte, s_reg.shift[31:8]};
    assign otp_fetch = consuming && s_reg.src_otp && (s_reg.otp_cnt == 3'h0) && !s_reg.otp_pend;
    assign flash_rd_en = consuming && !s_reg.src_otp;
    assign otp_rd_en = (s_reg.st == sbl_pkg::SBL_SEC_REQ) || otp_fetch;

    // ---------------------------------------------------------------
    // otp programming check
    // ---------------------------------------------------------------
    assign go = port_wr && (port_res_id == `SBL_RID_CTRL) && port_wdata[0];
    assign sector = s_reg.p_addr[10:9];
    assign blocked = !s_reg.sec_ok || s_reg.sec[`SBL_B_MASTER]
        || (port_from_jtag && s_reg.sec[`SBL_B_JTAG_OTP])
        || (!port_wdata[1] && s_reg.sec[`SBL_B_LOCK0 + sector]);

    always_comb
    begin
        s_next = s_reg;
        s_next.ram_we = 1'b0;
        s_next.wr_en = 1'b0;
        s_next.refused = 1'b0;
        s_next.rdata = 32'h00000000;
        s_next.dbg_s1 = debug_n_i;
        s_next.dbg_s2 = s_reg.dbg_s1;
        // debug pin input ignored when disabled
        s_next.dbg_enter = !s_reg.dbg_s2 && !s_reg.sec[`SBL_B_DBG_OFF];

        // otp word fetch, one cycle latency
        if (otp_fetch)
        begin
            s_next.otp_pend = 1'b1;
        end
        if (s_reg.otp_pend)
        begin
            s_next.otp_pend = 1'b0;
            s_next.otp_buf = otp_rd_data;
            s_next.otp_cnt = 3'h4;
            s_next.otp_addr = s_reg.otp_addr + 11'h001;
        end
        if (take)
        begin
            s_next.shift = word_in;
            s_next.bcnt = s_reg.bcnt + 2'h1;
            if (s_reg.src_otp)
            begin
                s_next.otp_buf = {8'h00, s_reg.otp_buf[31:8]};
                s_next.otp_cnt = s_reg.otp_cnt - 3'h1;
            end
            // crc over length and program only
            if (s_reg.st != sbl_pkg::SBL_CHK)
            begin
                s_next.crc = sbl_crc_byte(s_reg.crc, in_byte);
            end
        end

        case (s_reg.st)
            sbl_pkg::SBL_WAIT:
            begin
                s_next.pd = 1'b0;
                s_next.dly = s_reg.dly + 8'h01;
                if (s_reg.dly == 8'(DLY_M1))
                begin
                    s_next.st = sbl_pkg::SBL_SEC_REQ;
                end
            end
            sbl_pkg::SBL_SEC_REQ:
            begin
                s_next.st = sbl_pkg::SBL_SEC_GET;
            end
            sbl_pkg::SBL_SEC_GET:
            begin
                s_next.sec = otp_rd_data;
                s_next.sec_ok = 1'b1;
                s_next.src_otp = otp_rd_data[`SBL_B_OTP_BOOT];
                s_next.otp_addr = `SBL_OTP_BOOT_ROW;
                s_next.crc = `SBL_CRC_INIT;
                s_next.bcnt = 2'h0;
                s_next.st = sbl_pkg::SBL_LEN;
            end
            sbl_pkg::SBL_LEN:
            begin
                if (take && s_reg.bcnt == 2'h3)
                begin
                    s_next.len = word_in;
                    s_next.wcnt = 32'h00000000;
                    s_next.st = (word_in == 32'h00000000) ? sbl_pkg::SBL_CHK
                        : sbl_pkg::SBL_PROG;
                end
            end
            sbl_pkg::SBL_PROG:
            begin
                if (take && s_reg.bcnt == 2'h3)
                begin
                    s_next.ram_we = 1'b1;
                    s_next.ram_addr = `SBL_RAM_BASE + s_reg.wcnt[15:0];
                    s_next.ram_wdata = word_in;
                    s_next.wcnt = s_reg.wcnt + 32'h00000001;
                    if (s_reg.wcnt + 32'h00000001 == s_reg.len)
                    begin
                        s_next.st = sbl_pkg::SBL_CHK;
                    end
                end
            end
            sbl_pkg::SBL_CHK:
            begin
                if (take && s_reg.bcnt == 2'h3)
                begin
                    s_next.st = sbl_pkg::SBL_VERIFY;
                end
            end
            sbl_pkg::SBL_VERIFY:
            begin
                if (s_reg.shift == `SBL_SKIP_WORD || s_reg.shift == ~s_reg.crc)
                begin
                    s_next.run = 1'b1;
                    s_next.st = sbl_pkg::SBL_RUN;
                end
                else
                begin
                    s_next.fail = 1'b1;
                    s_next.st = sbl_pkg::SBL_FAIL;
                end
            end
            default:
            begin
            end
        endcase

        if (port_wr && port_res_id == `SBL_RID_ADDR)
        begin
            s_next.p_addr = port_wdata[15:0];
        end
        else if (port_wr && port_res_id == `SBL_RID_DATA)
        begin
            s_next.p_data = port_wdata;
        end
        else if (go)
        begin
            s_next.wr_en = !blocked;
            s_next.refused = blocked;
            s_next.wr_sec = port_wdata[1];
            s_next.wr_addr = s_reg.p_addr[10:0];
            s_next.wr_data = s_reg.p_data;
        end

        // register port
        if (reg_wr && reg_addr == `SBL_OFF_CTRL)
        begin
            s_next.brk = reg_wdata[0];
        end
        if (reg_rd)
        begin
            if (reg_addr == `SBL_OFF_PROT)
            begin
                s_next.rdata = s_reg.sec;
            end
            else if (reg_addr == `SBL_OFF_STAT)
            begin
                s_next.rdata = {24'h000000, s_reg.st, 1'b0, s_reg.src_otp, s_reg.fail,
                    s_reg.run};
            end
            else if (reg_addr == `SBL_OFF_CTRL)
            begin
                s_next.rdata = {31'h00000000, s_reg.brk};
            end
            else if (reg_addr == `SBL_OFF_CRC)
            begin
                s_next.rdata = ~s_reg.crc;
            end
            else
            begin
                s_next.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.pd <= 1'b1;
            s_reg.crc <= `SBL_CRC_INIT;
            s_reg.dbg_s1 <= 1'b1;
            s_reg.dbg_s2 <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign reg_rdata = s_reg.rdata;
    assign otp_rd_addr = (s_reg.st == sbl_pkg::SBL_SEC_REQ) ? `SBL_OTP_SEC_ROW : s_reg.otp_addr;
    assign ram_we = s_reg.ram_we;
    assign ram_addr = s_reg.ram_addr;
    assign ram_wdata = s_reg.ram_wdata;
    assign cpu_run = s_reg.run;
    assign cpu_start_addr = `SBL_RAM_BASE;
    assign boot_fail = s_reg.fail;
    assign gpio_pd_en = s_reg.pd;
    assign otp_wr_en = s_reg.wr_en;
    assign otp_wr_sec = s_reg.wr_sec;
    assign otp_wr_addr = s_reg.wr_addr;
    assign otp_wr_data = s_reg.wr_data;
    assign prog_refused = s_reg.refused;
    assign jtag_deny = !s_reg.sec_ok || s_reg.sec[`SBL_B_JTAG_OFF];
    assign link_deny = !s_reg.sec_ok || s_reg.sec[`SBL_B_LINK_OFF];
    assign otp_redund_en = s_reg.sec[`SBL_B_REDUND];
    assign jtag_otp_deny = !s_reg.sec_ok || s_reg.sec[`SBL_B_JTAG_OTP];
    assign user_code_ext = s_reg.sec[31:22];
    // never drive the debug pin when disabled
    assign debug_n_o = 1'b0;
    assign debug_n_oe = s_reg.brk && !s_reg.sec[`SBL_B_DBG_OFF];
    assign debug_enter = s_reg.dbg_enter;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_prog_go;
        port_wr && port_res_id == `SBL_RID_CTRL && port_wdata[0];
    endsequence

    sequence s_verify_bad;
        s_reg.st == sbl_pkg::SBL_VERIFY && s_reg.shift != `SBL_SKIP_WORD
            && s_reg.shift != ~s_reg.crc;
    endsequence

    property p_boot_delay;
        $fell(gpio_pd_en) |-> ##DLY_M1 s_reg.st == sbl_pkg::SBL_SEC_REQ;
    endproperty
    a_boot_delay: assert property (p_boot_delay) else $error("boot delay wrong");

    property p_boot_src;
        s_reg.st == sbl_pkg::SBL_SEC_GET |=> s_reg.src_otp == $past(otp_rd_data[5]);
    endproperty
    a_boot_src: assert property (p_boot_src) else $error("boot source wrong");

    property p_len_lsb;
        s_reg.st == sbl_pkg::SBL_LEN && take && s_reg.bcnt == 2'h3
            |=> s_reg.len[31:24] == $past(in_byte);
    endproperty
    a_len_lsb: assert property (p_len_lsb) else $error("length byte order wrong");

    property p_skip;
        s_reg.st == sbl_pkg::SBL_VERIFY && s_reg.shift == `SBL_SKIP_WORD |=> cpu_run && !boot_fail;
    endproperty
    a_skip: assert property (p_skip) else $error("skip word not honoured");

    property p_crc_fail;
        s_verify_bad |=> boot_fail && !cpu_run ##1 !cpu_run;
    endproperty
    a_crc_fail: assert property (p_crc_fail) else $error("bad crc started program");

    property p_first_word;
        $rose(s_reg.st == sbl_pkg::SBL_PROG) |-> !ram_we ##[1:400] ram_we && ram_addr == 16'h0000;
    endproperty
    a_first_word: assert property (p_first_word) else $error("first word not at base");

    property p_sector_lock;
        s_prog_go ##0 (!port_wdata[1] && s_reg.sec[`SBL_B_LOCK0 + sector])
            |=> !otp_wr_en && prog_refused;
    endproperty
    a_sector_lock: assert property (p_sector_lock) else $error("locked sector written");

    property p_master_lock;
        s_prog_go ##0 s_reg.sec[`SBL_B_MASTER] |=> !otp_wr_en && prog_refused;
    endproperty
    a_master_lock: assert property (p_master_lock) else $error("master lock ignored");

    property p_debug_off;
        s_reg.sec[`SBL_B_DBG_OFF] |-> !debug_n_oe ##2 !debug_enter;
    endproperty
    a_debug_off: assert property (p_debug_off) else $error("debug pin used while off");

endmodule : sbl_loader

`default_nettype wire

// >>> verif/sbl_mem_model.sv
// flash byte source and otp array beside the boot loader
`timescale 1ns/1ns
`default_nettype none

module sbl_mem_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic flash_rd_en,
    output logic flash_valid,
    output logic [7:0] flash_byte,
    input wire logic otp_rd_en,
    input wire logic [10:0] otp_rd_addr,
    output logic [31:0] otp_rd_data
);
    logic [31:0] otp_mem [0:2047];
    logic [7:0] fl_mem [0:15];
    int fl_len = 16;
    int idx;
    logic ph;
    logic [7:0] last_b;

    // slow mode offers a byte every other cycle
    assign flash_valid = (idx < fl_len) && (!slow || ph);
    assign flash_byte = flash_valid ? fl_mem[idx] : ~last_b;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idx <= 0;
            ph <= 1'b0;
            last_b <= 8'h00;
            otp_rd_data <= 32'h0;
        end
        else
        begin
            ph <= ~ph;
            if (flash_valid && flash_rd_en)
            begin
                idx <= idx + 1;
                last_b <= flash_byte;
            end
            otp_rd_data <= otp_rd_en ? otp_mem[otp_rd_addr] : ~otp_rd_data;
        end
    end
endmodule : sbl_mem_model
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench of the boot loader with memory model
`include "sbl_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic clk;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [23:0] port_res_id = 24'h0;
    logic [31:0] port_wdata = 32'h0;
    logic port_wr = 1'b0;
    logic port_from_jtag = 1'b0;
    logic slow = 1'b0;
    logic dbg_drv_n = 1'b1;
    logic [31:0] reg_rdata, otp_rd_data, otp_wr_data, ram_wdata, wd, crc_ok;
    logic flash_rd_en, flash_valid, otp_rd_en, otp_redund_en, otp_wr_en, otp_wr_sec, ws;
    logic prog_refused, ram_we, cpu_run, boot_fail, gpio_pd_en, jtag_deny, jtag_otp_deny;
    logic link_deny, debug_n_o, debug_n_oe, debug_enter, dbg_pin;
    logic [7:0] flash_byte;
    logic [10:0] otp_rd_addr, otp_wr_addr, wa, rd_a;
    logic [15:0] ram_addr, cpu_start_addr, a0;
    logic [9:0] user_code_ext;
    logic [31:0] ram_q [$];
    int bad_count = 0;
    int num_checks = 0;
    int n_wr = 0;
    int n_ref = 0;
    int cyc = 0;
    int t_rd = 0;
    logic [31:0] row_p [6] = '{32'h0, 32'h0, 32'h0, 32'hffc060a3, 32'h1000, 32'h0100};
    int row_m [6] = '{0, 1, 2, 0, 0, 1};

    // pulled-up debug line
    assign dbg_pin = (debug_n_oe ? debug_n_o : 1'b1) & dbg_drv_n;

    sbl_loader DUT
    (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_rd_en(flash_rd_en),
        .flash_valid(flash_valid), .flash_byte(flash_byte), .otp_rd_en(otp_rd_en),
        .otp_rd_addr(otp_rd_addr), .otp_rd_data(otp_rd_data), .otp_redund_en(otp_redund_en),
        .port_res_id(port_res_id), .port_wdata(port_wdata), .port_wr(port_wr),
        .port_from_jtag(port_from_jtag), .otp_wr_en(otp_wr_en), .otp_wr_sec(otp_wr_sec),
        .otp_wr_addr(otp_wr_addr), .otp_wr_data(otp_wr_data), .prog_refused(prog_refused),
        .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .cpu_run(cpu_run),
        .cpu_start_addr(cpu_start_addr), .boot_fail(boot_fail), .gpio_pd_en(gpio_pd_en),
        .jtag_deny(jtag_deny), .jtag_otp_deny(jtag_otp_deny), .link_deny(link_deny),
        .debug_n_i(dbg_pin), .debug_n_o(debug_n_o), .debug_n_oe(debug_n_oe),
        .debug_enter(debug_enter), .user_code_ext(user_code_ext)
    );

    sbl_mem_model mem
    (
        .clk(clk), .rst_n(rst_n), .slow(slow), .flash_rd_en(flash_rd_en),
        .flash_valid(flash_valid), .flash_byte(flash_byte), .otp_rd_en(otp_rd_en),
        .otp_rd_addr(otp_rd_addr), .otp_rd_data(otp_rd_data)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // records pulses seen at each edge
    always @(posedge clk)
    begin
        if (otp_wr_en === 1'b1)
        begin
            n_wr++;
            wa = otp_wr_addr;
            wd = otp_wr_data;
            ws = otp_wr_sec;
        end
        if (prog_refused === 1'b1)
            n_ref++;
        if (ram_we === 1'b1)
        begin
            ram_q.push_back(ram_wdata);
            if (ram_q.size() == 1)
                a0 = ram_addr;
        end
        if (otp_rd_en === 1'b1 && t_rd == 0)
        begin
            t_rd = cyc;
            rd_a = otp_rd_addr;
        end
        cyc++;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic pw(input logic [23:0] id, input logic [31:0] d, input logic jt);
        @(posedge clk);
        port_res_id <= id;
        port_wdata <= d;
        port_from_jtag <= jt;
        port_wr <= 1'b1;
        @(posedge clk);
        port_wr <= 1'b0;
    endtask : pw

    task automatic prog(input logic [10:0] a, input logic sec, input logic jt, input logic ok);
        int w0;
        int r0;
        w0 = n_wr;
        r0 = n_ref;
        pw(`SBL_RID_ADDR, {21'h0, a}, jt);
        pw(`SBL_RID_DATA, {16'h5a5a, 5'h0, a}, jt);
        pw(`SBL_RID_CTRL, {30'h0, sec, 1'b1}, jt);
        repeat (3) @(posedge clk);
        chk(n_wr - w0 + 2 * (n_ref - r0), ok ? 1 : 2);
        if (ok)
            chk({ws, wd[31:16], wa}, {sec, 16'h5a5a, a});
    endtask : prog

    function automatic logic [31:0] crc_img();
        logic [31:0] c;
        logic [31:0] v [3];
        c = `SBL_CRC_INIT;
        v = '{32'h2, 32'h11223344, 32'h55667788};
        for (int i = 0; i < 12; i++)
        begin
            c ^= {24'h0, v[i / 4][8 * (i % 4) +: 8]};
            repeat (8) c = c[0] ? (c >> 1) ^ `SBL_CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction : crc_img

    // image load, reset, boot and post-boot checks
    task automatic boot(input logic [31:0] p, input int m, input logic early);
        logic [31:0] w [4];
        logic [31:0] d;
        w = '{32'h2, 32'h11223344, 32'h55667788,
            m == 1 ? `SBL_SKIP_WORD : (m == 2 ? ~crc_ok : crc_ok)};
        for (int i = 0; i < 4; i++)
        begin
            mem.otp_mem[i] = w[i];
            for (int j = 0; j < 4; j++)
                mem.fl_mem[4 * i + j] = w[i][8 * j +: 8];
        end
        mem.otp_mem[11'h7ff] = p;
        @(posedge clk);
        rst_n <= 1'b0;
        slow <= (m == 1);
        repeat (12) @(posedge clk);
        chk({gpio_pd_en, jtag_deny, cpu_run, reg_rdata}, {3'b110, 32'h0});
        rst_n <= 1'b1;
        cyc = 0;
        t_rd = 0;
        ram_q.delete();
        if (early)
            prog(11'h010, 1'b0, 1'b0, 1'b0);
        for (int k = 0; k < 3000 && cpu_run !== 1'b1 && boot_fail !== 1'b1; k++)
            @(posedge clk);
        #1;
        chk(t_rd >= 150 && t_rd <= 1500, 1'b1);
        chk(rd_a, 11'h7ff);
        chk({cpu_run, boot_fail}, {m != 2, m == 2});
        chk({ram_q.size() == 2, a0, cpu_start_addr}, {1'b1, 32'h0});
        chk(ram_q[0], 32'h11223344);
        chk(ram_q[1], 32'h55667788);
        chk(mem.idx, p[5] ? 0 : 16);
        chk({jtag_deny, link_deny, jtag_otp_deny, otp_redund_en}, {p[0], p[1], p[13], p[7]});
        chk(user_code_ext, p[31:22]);
        rd(`SBL_OFF_CRC, d);
        chk(d, crc_ok);
        wr(`SBL_OFF_PROT, ~p);
        rd(`SBL_OFF_PROT, d);
        chk(d, p);
        rd(`SBL_OFF_STAT, d);
        chk(d[2:0], {p[5], m == 2, m != 2});
        rd(8'h10, d);
        chk(d, 32'h0);
        prog(11'h010, 1'b0, 1'b0, !(p[12] | p[8]));
        @(posedge clk);
        dbg_drv_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk(debug_enter, !p[14]);
        @(posedge clk);
        dbg_drv_n <= 1'b1;
        wr(`SBL_OFF_CTRL, 32'h1);
        #1 chk({debug_n_oe, debug_n_o}, {!p[14], 1'b0});
        wr(`SBL_OFF_CTRL, 32'h0);
    endtask : boot

    initial
    begin
        crc_ok = crc_img();
        for (int r = 0; r < 6; r++)
            boot(row_p[r], row_m[r], r == 0);
        boot(32'h00002200, 0, 1'b0);
        prog(11'h210, 1'b0, 1'b0, 1'b0);
        prog(11'h010, 1'b0, 1'b1, 1'b0);
        prog(11'h210, 1'b1, 1'b0, 1'b1);
        prog(11'h1ff, 1'b0, 1'b0, 1'b1);
        tally_and_finish();
    end

    initial
    begin
        #2000000;
        bad_count++;
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
